// File: logic/bank_fsm.sv
/*
 One bank's state machine with its own cycle counter.
 Assumes decoded command strobes from the top, already qualified by bank.
*/
`timescale 1ns/1ns
`include "sdram_arb_defs.svh"
module bank_fsm #(
   parameter int unsigned ROW_PRECHARGE_TIME  = 2,
   parameter int unsigned ROW_TO_COLUMN_DELAY = 2,
   parameter int unsigned WRITE_RECOVERY_TIME  = 2,
   parameter int unsigned BL   = 4
) (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       act_i,
   input  wire logic                       rd_i,
   input  wire logic                       wr_i,
   input  wire logic                       ap_i,
   input  wire logic                       pre_i,
   input  wire logic                       stop_i,
   input  wire logic                       intr_i,
   input  wire logic                       global_hold,
   output sdram_arb_pkg::bank_state_t      state,
   output logic                            bursting
);
   import sdram_arb_pkg::*;
   bank_state_t          st_q, st_d;        // Bank state
   logic [`CNT_W-1:0]    cnt_q, cnt_d;      // Timer counting down
   wire                  cnt_done = (cnt_q == '0);
   wire [`CNT_W-1:0]     trp_c  = `CNT_W'(ROW_PRECHARGE_TIME - 1);
   wire [`CNT_W-1:0]     row_to_column_delay_c = `CNT_W'(ROW_TO_COLUMN_DELAY - 1);
   wire [`CNT_W-1:0]     twr_c  = `CNT_W'(WRITE_RECOVERY_TIME - 1);
   wire [`CNT_W-1:0]     bl_c   = `CNT_W'(BL - 1);

   assign state    = st_q;
   assign bursting = (st_q == BK_READ) || (st_q == BK_WRITE) ||
                     (st_q == BK_READ_AP) || (st_q == BK_WRITE_AP);

   // Next state; the timer is loaded on every entry to a timed state, including the auto precharge steps
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_done ? cnt_q : cnt_q - `CNT_W'(1);
      unique case (st_q)
         BK_IDLE: begin
            // Precharge to idle bank is a no-op
            if (act_i && !global_hold) begin
               st_d  = BK_ACTIVATING;
               cnt_d = row_to_column_delay_c;
            end
         end
         BK_ACTIVATING: if (cnt_done) st_d = BK_ACTIVE;
         BK_ACTIVE, BK_READ, BK_WRITE: begin
            if (pre_i) begin
               st_d  = BK_PRECHARGING;
               cnt_d = trp_c;
            end else if (rd_i || wr_i) begin
               st_d  = rd_i ? (ap_i ? BK_READ_AP : BK_READ)
                            : (ap_i ? BK_WRITE_AP : BK_WRITE);
               cnt_d = bl_c;
            end else if (stop_i || intr_i) begin
               st_d = BK_ACTIVE;
            end else if (st_q != BK_ACTIVE && cnt_done) begin
               st_d = BK_ACTIVE;        // Burst ran out
            end
         end
         BK_READ_AP: begin
            if (intr_i || stop_i || cnt_done) begin
               st_d  = BK_PRECHARGING;
               cnt_d = trp_c;
            end
         end
         BK_WRITE_AP: begin
            if (intr_i || stop_i || cnt_done) begin
               st_d  = BK_RECOVER_AP;
               cnt_d = twr_c;
            end
         end
         BK_RECOVER_AP: if (cnt_done) begin
            st_d  = BK_PRECHARGING;
            cnt_d = trp_c;
         end
         BK_PRECHARGING: if (cnt_done) st_d = BK_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q  <= BK_IDLE;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// File: logic/sdram_arb_defs.svh
/*
 Holds the timing counts and field positions shared by the bank command logic.
 Assumes a 100 MHz clock; the NS figures are in nanoseconds and are converted to cycles in the arbiter module.
*/
`ifndef SDRAM_ARB_DEFS_SVH
`define SDRAM_ARB_DEFS_SVH
`define CLK_PERIOD_NS        10
`define ROW_PRECHARGE_NS     20
`define REFRESH_CYCLE_NS     60
`define MODE_SET_DELAY_CLK   2
`define WRITE_RECOVERY_NS    15
`define ROW_TO_COLUMN_NS     20
`define CAS_LATENCY_CLK      3
`define BURST_LEN_CLK        4
`define AP_BIT               10
`define CNT_W                8
`endif

// File: logic/sdram_arb_pkg.sv
/*
 Types for the bank command logic: the decoded command and bank states.
 Assumes the defines header is compiled alongside.
*/
package sdram_arb_pkg;
   typedef enum logic [3:0] {
      CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
      CMD_BURST_STOP, CMD_REFRESH, CMD_LOAD_MODE
   } cmd_t;
   typedef enum logic [3:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE, BK_READ_AP,
      BK_WRITE_AP, BK_RECOVER_AP, BK_PRECHARGING
   } bank_state_t;
endpackage

// File: logic/sdram_bank_arb.sv
/*
 Four-bank command acceptance: decodes pins, runs bank machines, tracks
 the global refresh, mode-load and precharge-all holds and the data bus owner.
 Assumes commands sampled synchronously on clk, clock enable always high.
*/
// What this block does
// - Auto precharge bank returns idle after precharge
// - Refresh holds device until refresh cycle done
// - Mode load holds device until set delay
// - Precharge all idles every bank after precharge, except a bank still activating
// - Burst stop ends most recent burst
// - Precharge to idle bank is no-op
// - Deselect ignored, no-op continues operations
// - Pin code decodes into command
// - Idle bank never blocks other banks
// - Precharge elsewhere leaves running burst alone
// - Interrupted auto precharge burst starts precharge
// - Read after read owns bus after latency
// - Write interrupts read at registration
// - Read interrupts write, last data before
// - Write interrupts write, last data before
// - Read interrupt starts auto precharge now
// - Write interrupt starts read auto precharge
// - Write auto precharge waits recovery first
// - Address bit ten selects auto precharge
`timescale 1ns/1ns
`include "sdram_arb_defs.svh"
module sdram_bank_arb #(
   parameter int unsigned NBANK = 4,
   parameter int unsigned AW    = 12,
   parameter int unsigned CL    = `CAS_LATENCY_CLK,
   parameter int unsigned BL    = `BURST_LEN_CLK
) (
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        cs_n,
   input  wire logic                        ras_n,
   input  wire logic                        cas_n,
   input  wire logic                        we_n,
   input  wire logic [1:0]                  bank_select_bits,
   input  wire logic [AW-1:0]               addr,
   output sdram_arb_pkg::cmd_t              cmd_q,
   output logic                             all_idle_q,
   output logic                             busy_hold_q,
   output logic [1:0]                       data_bank_q,
   output logic                             data_out_q,
   output logic                             data_in_q,
   output logic [NBANK-1:0]                 bank_idle_q
);
   import sdram_arb_pkg::*;
   localparam int unsigned ROW_PRECHARGE_TIME  = (`ROW_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int unsigned REFRESH_CYCLE_TIME  = (`REFRESH_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int unsigned MODE_SET_DELAY = `MODE_SET_DELAY_CLK;
   localparam int unsigned WRITE_RECOVERY_TIME  = (`WRITE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int unsigned ROW_TO_COLUMN_DELAY = (`ROW_TO_COLUMN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   // Pin decode
   wire   sel    = !cs_n;
   wire   c_act  = sel && !ras_n &&  cas_n &&  we_n;
   wire   c_rd   = sel &&  ras_n && !cas_n &&  we_n;
   wire   c_wr   = sel &&  ras_n && !cas_n && !we_n;
   wire   c_pre  = sel && !ras_n &&  cas_n && !we_n;
   wire   c_stop = sel &&  ras_n &&  cas_n && !we_n;
   wire   c_ref  = sel && !ras_n && !cas_n &&  we_n;
   wire   c_lmr  = sel && !ras_n && !cas_n && !we_n;
   wire   ap     = addr[`AP_BIT];
   wire   pre_all = c_pre && ap;

   // Global hold state: refresh, mode load, precharge all
   typedef enum logic [1:0] {G_RUN, G_REFRESH, G_MODE, G_PREALL} glob_t;
   glob_t               g_q, g_d;        // Global state
   logic [`CNT_W-1:0]   gcnt_q, gcnt_d;  // Global timer
   wire                 hold = (g_q != G_RUN);
   wire                 gdone = (gcnt_q == '0);

   // Commands only act when no global hold is running
   wire   live   = !hold;
   logic [NBANK-1:0] tgt;                // One-hot bank target
   always_comb begin
      tgt = '0;
      tgt[bank_select_bits] = 1'b1;
   end

   // Most recent burst owner, for stop and interrupts
   logic [1:0]        last_q;            // Bank of latest burst
   logic              last_v_q;          // A burst has been started
   wire               new_burst = live && (c_rd || c_wr);
   bank_state_t       bst   [NBANK];     // Per-bank state
   logic [NBANK-1:0]  burst;             // Per-bank bursting

   genvar g;
   generate
      for (g = 0; g < NBANK; g++) begin : g_bank
         wire mine = tgt[g];
         // Another bank's burst interrupts this one
         wire intr = new_burst && !mine && last_v_q && (last_q == 2'(g));
         bank_fsm #(.ROW_PRECHARGE_TIME(ROW_PRECHARGE_TIME), .ROW_TO_COLUMN_DELAY(ROW_TO_COLUMN_DELAY), .WRITE_RECOVERY_TIME(WRITE_RECOVERY_TIME), .BL(BL)) u_bank (
            .clk         (clk),
            .rstn        (rstn),
            .act_i       (live && c_act && mine),
            .rd_i        (live && c_rd && mine),
            .wr_i        (live && c_wr && mine),
            .ap_i        (ap),
            .pre_i       (live && c_pre && (mine || ap)),
            .stop_i      (live && c_stop && last_v_q && (last_q == 2'(g))),
            .intr_i      (intr),
            .global_hold (hold),
            .state       (bst[g]),
            .bursting    (burst[g])
         );
      end
   endgenerate

   // Per-bank idle flags; a precharge to an idle bank leaves them set
   wire [NBANK-1:0] idle_w;
   for (g = 0; g < NBANK; g++) begin : g_idle
      assign idle_w[g] = (bst[g] == BK_IDLE);
   end
   wire all_idle = &idle_w;

   // Global hold machine
   always_comb begin
      g_d    = g_q;
      gcnt_d = gdone ? gcnt_q : gcnt_q - `CNT_W'(1);
      unique case (g_q)
         G_RUN: begin
            if (c_ref && all_idle) begin
               g_d    = G_REFRESH;
               gcnt_d = `CNT_W'(REFRESH_CYCLE_TIME - 1);
            end else if (c_lmr && all_idle) begin
               g_d    = G_MODE;
               gcnt_d = `CNT_W'(MODE_SET_DELAY - 1);
            end else if (pre_all) begin
               g_d    = G_PREALL;
               gcnt_d = `CNT_W'(ROW_PRECHARGE_TIME - 1);
            end
         end
         G_REFRESH, G_MODE, G_PREALL: if (gdone) g_d = G_RUN;
      endcase
   end

   // Data bus owner pipeline: reads after latency, writes at once
   logic [CL-1:0]       rd_pipe_q;     // Read data valid pipe
   logic [1:0]          rd_bank_q [CL];// Read bank pipe
   wire                 rd_go = live && c_rd;
   wire                 wr_go = live && c_wr;
   // A write or a stop cancels read data still waiting out the latency
   wire                 cut   = wr_go || (live && c_stop);
   logic [`CNT_W-1:0]   beat_q;        // Remaining burst beats

   // Command, hold and owner registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         g_q        <= G_RUN;
         gcnt_q     <= '0;
         last_q     <= 2'h0;
         last_v_q   <= 1'b0;
         rd_pipe_q  <= '0;
         for (int i = 0; i < CL; i++) rd_bank_q[i] <= 2'h0;
      end else begin
         g_q    <= g_d;
         gcnt_q <= gcnt_d;
         if (new_burst) begin
            last_q   <= bank_select_bits;
            last_v_q <= 1'b1;
         end
         // Cancelled reads never reach the bus
         if (cut) rd_pipe_q <= '0;
         else rd_pipe_q <= {rd_pipe_q[CL-2:0], rd_go};
         rd_bank_q[0] <= bank_select_bits;
         for (int i = 1; i < CL; i++) rd_bank_q[i] <= rd_bank_q[i-1];
      end
   end

   // Bus direction and beat count
   always_ff @(posedge clk) begin
      if (!rstn) begin
         beat_q      <= '0;
         data_bank_q <= 2'h0;
         data_out_q  <= 1'b0;
         data_in_q   <= 1'b0;
      end else if (wr_go) begin
         beat_q      <= `CNT_W'(BL - 1);
         data_in_q   <= 1'b1;
         data_out_q  <= 1'b0;
         data_bank_q <= bank_select_bits;
      end else if (live && c_stop) begin
         // Stop ends whichever burst holds the bus
         beat_q      <= '0;
         data_out_q  <= 1'b0;
         data_in_q   <= 1'b0;
      end else if (rd_pipe_q[CL-1]) begin
         beat_q      <= `CNT_W'(BL - 1);
         data_out_q  <= 1'b1;
         data_in_q   <= 1'b0;
         data_bank_q <= rd_bank_q[CL-1];
      end else if (rd_go && data_in_q) begin
         // Read ends a write at once; its own data follows later
         beat_q      <= '0;
         data_in_q   <= 1'b0;
      end else if (beat_q != '0) begin
         beat_q <= beat_q - `CNT_W'(1);
      end else begin
         data_out_q <= 1'b0;
         data_in_q  <= 1'b0;
      end
   end

   // Status outputs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmd_q       <= CMD_INHIBIT;
         all_idle_q  <= 1'b1;
         busy_hold_q <= 1'b0;
         bank_idle_q <= '1;
      end else begin
         // Pin code back to a named command
         cmd_q       <= !sel ? CMD_INHIBIT : c_act ? CMD_ACTIVE : c_rd ? CMD_READ :
                        c_wr ? CMD_WRITE : c_pre ? CMD_PRECHARGE :
                        c_stop ? CMD_BURST_STOP : c_ref ? CMD_REFRESH :
                        c_lmr ? CMD_LOAD_MODE : CMD_NOP;
         all_idle_q  <= all_idle && !hold;
         busy_hold_q <= hold;
         bank_idle_q <= idle_w;
      end
   end

   // Checks
   property p_refresh_hold;
      @(posedge clk) disable iff (!rstn)
      (g_q == G_RUN && c_ref && all_idle) |=> hold [*5];
   endproperty
   a_refresh_hold: assert property (p_refresh_hold) else $error("refresh hold short");

   property p_mode_hold;
      @(posedge clk) disable iff (!rstn)
      (g_q == G_RUN && c_lmr && all_idle && !c_ref) |=> hold ##1 hold ##1 !hold;
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode hold wrong");

   property p_preall;
      @(posedge clk) disable iff (!rstn)
      (g_q == G_RUN && pre_all && !c_ref && !c_lmr) |=> hold ##1 hold ##1 !hold;
   endproperty
   a_preall: assert property (p_preall) else $error("precharge all wrong");

   property p_idle_pre;
      @(posedge clk) disable iff (!rstn)
      (live && c_pre && !ap && idle_w[bank_select_bits]) |=> idle_w[$past(bank_select_bits)];
   endproperty
   a_idle_pre: assert property (p_idle_pre) else $error("idle precharge changed bank");

   // Read reaches the end of the pipe unless a write or stop cancels it
   property p_read_owner;
      @(posedge clk) disable iff (!rstn)
      (rd_go ##1 !cut ##1 !cut) |=> rd_pipe_q[CL-1];
   endproperty
   a_read_owner: assert property (p_read_owner) else $error("read latency wrong");

   property p_write_take;
      @(posedge clk) disable iff (!rstn)
      wr_go |=> (data_in_q && !data_out_q);
   endproperty
   a_write_take: assert property (p_write_take) else $error("write did not take bus");

   property p_last_burst;
      @(posedge clk) disable iff (!rstn)
      new_burst |=> (last_q == $past(bank_select_bits)) && last_v_q;
   endproperty
   a_last_burst: assert property (p_last_burst) else $error("burst owner lost");

   property p_global_end;
      @(posedge clk) disable iff (!rstn)
      (hold && gdone) |=> !hold;
   endproperty
   a_global_end: assert property (p_global_end) else $error("hold did not end");

   // Stop leaves the latest burst bank no longer bursting
   property p_stop_ends;
      @(posedge clk) disable iff (!rstn)
      (live && c_stop && last_v_q) |=> !burst[$past(last_q)];
   endproperty
   a_stop_ends: assert property (p_stop_ends) else $error("stop left burst running");

   // Precharge aimed at another bank keeps read data flowing
   property p_pre_keep;
      @(posedge clk) disable iff (!rstn)
      (live && c_pre && !ap && data_out_q && (beat_q != '0) &&
       (bank_select_bits != data_bank_q)) |=> data_out_q;
   endproperty
   a_pre_keep: assert property (p_pre_keep) else $error("precharge cut a burst");

   // Activate to an idle bank is taken whatever the others do
   property p_act_takes;
      @(posedge clk) disable iff (!rstn)
      (live && c_act && idle_w[bank_select_bits]) |=> !idle_w[$past(bank_select_bits)];
   endproperty
   a_act_takes: assert property (p_act_takes) else $error("activate not taken");

   c_refresh: cover property (@(posedge clk) disable iff (!rstn) g_q == G_REFRESH);
   c_preall:  cover property (@(posedge clk) disable iff (!rstn) g_q == G_PREALL);
   c_rd_rd:   cover property (@(posedge clk) disable iff (!rstn) rd_go ##1 rd_go);
   c_wr_rd:   cover property (@(posedge clk) disable iff (!rstn) wr_go ##1 rd_go);
   c_rd_stop: cover property (@(posedge clk) disable iff (!rstn) rd_go ##1 (live && c_stop));
endmodule

// File: verif/sdram_bank_arb_test.sv
/*
 Self-checking bench for the four-bank command logic.
 Assumes the default parameters and 20 ns row precharge at 100 MHz.
*/
`timescale 1ns/1ns
module sdram_bank_arb_test;
   import sdram_arb_pkg::*;
   localparam int ROW_PRECHARGE_TIME = 2;       // Row precharge in cycles
   logic        clk = 1'b0;      // 100 MHz clock
   logic        rstn = 1'b0;     // Synchronous reset
   logic        cs_n, ras_n, cas_n, we_n;
   logic [1:0]  bank_select_bits;
   logic [11:0] addr;
   cmd_t        cmd_q;
   logic        all_idle_q, busy_hold_q, data_out_q, data_in_q;
   logic [1:0]  data_bank_q, first_bank, last_bank;
   logic [3:0]  bank_idle_q;
   int          n_out, n_in, n_busy;  // Beat and hold counters
   int          n_mismatch = 0;
   int          checks = 0;
   // Clock
   always #5 clk = ~clk;
   sdram_ctl_model ctl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .bank_select_bits(bank_select_bits), .addr(addr));
   sdram_bank_arb dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .bank_select_bits(bank_select_bits), .addr(addr), .cmd_q(cmd_q),
      .all_idle_q(all_idle_q), .busy_hold_q(busy_hold_q), .data_bank_q(data_bank_q),
      .data_out_q(data_out_q), .data_in_q(data_in_q), .bank_idle_q(bank_idle_q));
   // Count beats and hold cycles, note data bus owners
   always @(posedge clk) begin
      if (data_out_q === 1'b1) begin
         if (n_out == 0) first_bank <= data_bank_q;
         last_bank <= data_bank_q;
         n_out <= n_out + 1;
      end
      if (data_in_q === 1'b1) n_in <= n_in + 1;
      if (busy_hold_q === 1'b1) n_busy <= n_busy + 1;
   end
   task automatic print_verdict();
      if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
         n_mismatch++;
      end
   endtask
   task automatic idle(input int n);
      repeat (n) ctl.send(CMD_INHIBIT, 2'h0, 1'b0);
   endtask
   task automatic clr();
      n_out = 0;
      n_in = 0;
      n_busy = 0;
   endtask
   // Close every row
   task automatic close();
      ctl.send(CMD_PRECHARGE, 2'h0, 1'b1);
      idle(4);
   endtask
   task automatic act2(input logic [1:0] a, input logic [1:0] b);
      ctl.send(CMD_ACTIVE, a, 1'b0);
      ctl.send(CMD_ACTIVE, b, 1'b0);
      idle(3);
   endtask
   // Decoded command shows right after the edge that took it
   task automatic expect_cmd(input cmd_t e);
      check(cmd_q, e);
   endtask
   // Bounded wait for a bank to go idle
   task automatic wait_idle(input int b, output int cnt);
      cnt = 0;
      while (bank_idle_q[b] !== 1'b1 && cnt < 30) begin
         idle(1);
         cnt++;
      end
      if (cnt == 30) begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   task automatic t_reset();
      check(cmd_q, CMD_INHIBIT);
      check({all_idle_q, busy_hold_q, data_out_q, data_in_q}, 4'h8);
      check(bank_idle_q, 4'hf);
   endtask
   // Each pin code except refresh and mode load decodes to its command
   task automatic t_decode();
      cmd_t seq[10] = '{CMD_NOP, CMD_INHIBIT, CMD_ACTIVE, CMD_NOP, CMD_NOP, CMD_READ,
                        CMD_BURST_STOP, CMD_WRITE, CMD_BURST_STOP, CMD_PRECHARGE};
      foreach (seq[i]) begin
         ctl.send(seq[i], 2'h3, 1'b0);
         expect_cmd(seq[i]);
      end
      idle(8);
      check(bank_idle_q, 4'hf);
   endtask
   // Global hold lasts its exact count, then all idle
   task automatic t_hold(input cmd_t c, input logic ap, input int exp);
      clr();
      ctl.send(c, 2'h1, ap);
      idle(12);
      check(n_busy, exp);
      check({all_idle_q, bank_idle_q}, 5'h1f);
   endtask
   // Precharge to an idle bank changes nothing
   task automatic t_idle_pre();
      ctl.send(CMD_ACTIVE, 2'h1, 1'b0);
      idle(3);
      ctl.send(CMD_PRECHARGE, 2'h2, 1'b0);
      idle(3);
      check(bank_idle_q, 4'hd);
      close();
   endtask
   // Two commands to banks 1 and 2, gap idle cycles between; eo < 0 means cut short
   task automatic t_pair(input cmd_t c1, input cmd_t c2, input int gap,
                         input int eo, input int ei, input logic [3:0] own);
      act2(2'h1, 2'h2);
      clr();
      ctl.send(c1, 2'h1, 1'b0);
      idle(gap);
      ctl.send(c2, (c2 == CMD_BURST_STOP) ? 2'h1 : 2'h2, 1'b0);
      idle(12);
      if (eo < 0) check(n_out < 4, 1'b1);
      else check(n_out, eo);
      check(n_in, ei);
      if (eo > 0) check({first_bank, last_bank}, own);
      close();
   endtask
   // Auto precharge on bank 1, optionally cut by bank 2
   task automatic t_cut(input cmd_t c1, input cmd_t c2, input int lo, input int hi);
      int cnt;
      act2(2'h1, 2'h2);
      ctl.send(c1, 2'h1, 1'b1);
      ctl.send(c2, 2'h2, 1'b0);
      check(bank_idle_q[1], 1'b0);
      wait_idle(1, cnt);
      check(cnt >= lo && cnt <= hi, 1'b1);
      close();
   endtask
   // Main sequence
   initial begin
      clr();
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      t_reset();
      t_decode();
      t_hold(CMD_REFRESH, 1'b0, 6);
      t_hold(CMD_LOAD_MODE, 1'b0, 2);
      act2(2'h0, 2'h2);
      t_hold(CMD_PRECHARGE, 1'b1, ROW_PRECHARGE_TIME);
      t_idle_pre();
      t_pair(CMD_READ, CMD_READ, 0, 5, 0, 4'h6);
      t_pair(CMD_READ, CMD_WRITE, 0, 0, 4, 4'h0);
      t_pair(CMD_WRITE, CMD_READ, 1, 4, 2, 4'ha);
      t_pair(CMD_WRITE, CMD_WRITE, 1, 0, 6, 4'h0);
      t_pair(CMD_READ, CMD_PRECHARGE, 3, 4, 0, 4'h5);
      t_pair(CMD_READ, CMD_BURST_STOP, 0, -1, 0, 4'h0);
      t_cut(CMD_READ, CMD_INHIBIT, 4, 20);
      t_cut(CMD_READ, CMD_READ, 1, 4);
      t_cut(CMD_READ, CMD_WRITE, 1, 4);
      t_cut(CMD_WRITE, CMD_READ, 3, 6);
      t_cut(CMD_WRITE, CMD_WRITE, 3, 6);
      print_verdict();
   end
endmodule

// File: verif/sdram_ctl_model.sv
/*
 Memory controller model that drives the command, bank and address pins.
 Assumes every caller is at a falling clock edge when it calls send.
*/
`timescale 1ns/1ns
module sdram_ctl_model (
   input  wire logic        clk,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [1:0]       bank_select_bits,
   output logic [11:0]      addr
);
   import sdram_arb_pkg::*;
   // Deselected at time zero
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'h9;
      bank_select_bits = 2'h0;
      addr = 12'h0a5;
   end
   // One command for one edge; returns at the next falling edge
   task automatic send(input cmd_t c, input logic [1:0] b, input logic ap);
      logic [3:0] p;
      case (c)
         CMD_NOP:        p = 4'h7;
         CMD_ACTIVE:     p = 4'h3;
         CMD_READ:       p = 4'h5;
         CMD_WRITE:      p = 4'h4;
         CMD_PRECHARGE:  p = 4'h2;
         CMD_BURST_STOP: p = 4'h6;
         CMD_REFRESH:    p = 4'h1;
         CMD_LOAD_MODE:  p = 4'h0;
         // Deselect: other pins toggle so stale values never help
         default:        p = {1'b1, ~ras_n, ~cas_n, ~we_n};
      endcase
      {cs_n, ras_n, cas_n, we_n} = p;
      bank_select_bits = (c == CMD_INHIBIT) ? ~bank_select_bits : b;
      addr = (c == CMD_INHIBIT) ? ~addr : {1'b0, ap, 10'h0a5};
      @(negedge clk);
   endtask
endmodule
